// ==== rtl/vpic_top.sv ====
`timescale 1ns/1ps
module vpic_top import vpic_pkg::*; #(
    parameter int NUM_SYS = 4,
    parameter logic [NSRC-1:0] EXT_SRC = 32'hC000_0001
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DW-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DW-1:0] hrdata,
    input wire logic fast_source_pin,
    input wire logic [NUM_SYS-1:0] system_source,
    input wire logic [NSRC-1:2] peripheral_source_id,
    output logic fast_request_n,
    output logic normal_request_n,
    output logic wake_request
);
    // Source 0 is always treated as an external pin.
    localparam logic [NSRC-1:0] EXT_MASK = EXT_SRC | SRC_FAST_ONLY;

    vpic_bus_t state;
    vpic_req_t req;
    logic take;
    logic wr_go;
    logic rd_go;
    logic [NUM_W-1:0] idx;
    logic wr_mode, wr_vec, wr_en, wr_dis, wr_clr, wr_set, wr_eos;
    logic wr_spur, wr_ctrl, wr_ffe, wr_ffd;
    logic rd_ivr, rd_fvr;
    logic [NSRC-1:0] raw, s1, s2, s3, filt, lvl, eff, eff_prev;
    logic [NSRC-1:0] edge_mode, det_edge, edge_q, pend;
    logic [NSRC-1:0] mask, ffe, ffe_eff, cand, auto_clr;
    vpic_mode_t mode [NSRC];
    logic [DW-1:0] vec [NSRC];
    logic [DW-1:0] spurious;
    logic gmask;
    logic [NUM_W-1:0] best;
    logic [PRIO_W-1:0] best_prio;
    logic found;
    logic higher;
    logic fiq_cond;
    logic [NUM_W-1:0] stk_num [STACK_DEPTH];
    logic [PRIO_W-1:0] stk_lvl [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [2:0] top;
    logic push, pop;
    logic [DW-1:0] rd_val;

    // Bus front end: writes finish with no wait, reads add one wait state.
    // The wait lets read side effects act after any preceding write landed.
    assign take = hsel & hready & htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= BUS_IDLE;
            req <= '0;
            hreadyout <= 1'b1;
        end else begin
            unique case (state)
                BUS_IDLE, BUS_WRITE: begin
                    if (take) begin
                        req <= '{addr: haddr[AW-1:0], write: hwrite};
                        state <= hwrite ? BUS_WRITE : BUS_READ;
                        hreadyout <= hwrite;
                    end else begin
                        state <= BUS_IDLE;
                    end
                end
                BUS_READ: begin
                    state <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // The response is always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Address decode of the captured transfer.
    assign wr_go = (state == BUS_WRITE);
    assign rd_go = (state == BUS_READ);
    assign idx = req.addr[IDX_LSB +: NUM_W];
    assign wr_mode = wr_go && ((req.addr & BANK_MASK) == OFS_MODE_BASE);
    assign wr_vec = wr_go && ((req.addr & BANK_MASK) == OFS_VECTOR_BASE);
    assign wr_en = wr_go && (req.addr == OFS_ENABLE_CMD);
    assign wr_dis = wr_go && (req.addr == OFS_DISABLE_CMD);
    assign wr_clr = wr_go && (req.addr == OFS_CLEAR_CMD);
    assign wr_set = wr_go && (req.addr == OFS_SET_CMD);
    assign wr_eos = wr_go && (req.addr == OFS_END_OF_SERVICE);
    assign wr_spur = wr_go && (req.addr == OFS_SPURIOUS_VECTOR);
    assign wr_ctrl = wr_go && (req.addr == OFS_GENERAL_CTRL);
    assign wr_ffe = wr_go && (req.addr == OFS_FAST_FORCE_EN);
    assign wr_ffd = wr_go && (req.addr == OFS_FAST_FORCE_DIS);
    assign rd_ivr = rd_go && (req.addr == OFS_VECTOR_READ);
    assign rd_fvr = rd_go && (req.addr == OFS_FAST_VECTOR_READ);

    // Source numbering: pin, system OR, then peripheral identifiers.
    assign raw = {peripheral_source_id, // [RQ11] [RQ12]
                  |system_source, // [RQ10]
                  fast_source_pin}; // [RQ9]

    // Three-stage synchroniser; a change counts once stages two and three
    // agree, so a glitch shorter than a clock cannot latch twice.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            filt <= (s2 & s3) | (filt & (s2 | s3)); // [RQ24]
        end
    end

    // Every external path takes the same three stages, whatever pin mux
    // sits in front of it, so its latency does not depend on routing.
    assign lvl = (EXT_MASK & filt) | (~EXT_MASK & raw); // [RQ23] [RQ24]

    // Condition select: internal sources use only the edge bit and stay
    // active high; external ones may also invert.
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            eff[i] = lvl[i] ^ // [RQ3] [RQ4]
                (EXT_MASK[i] & mode[i].cond[COND_INVERT_BIT]);
            edge_mode[i] = mode[i].cond[COND_EDGE_BIT]; // [RQ3] [RQ4]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eff_prev <= '0;
        end else begin
            eff_prev <= eff;
        end
    end

    assign det_edge = eff & ~eff_prev & edge_mode;
    assign pend = (edge_mode & edge_q) | (~edge_mode & eff); // [RQ20]

    // Edge latches. A new edge wins over any clear in the same cycle.
    // Bits in level mode are held at zero, so set and clear do nothing there.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_q <= '0;
        end else begin
            edge_q <= ((edge_q & ~(auto_clr | (wr_clr ? hwdata : '0)))
                      | det_edge | (wr_set ? hwdata : '0)) // [RQ15]
                      & edge_mode; // [RQ16]
        end
    end

    // Vector read clears only the winner, and never a fast-forced one.
    always_comb begin
        auto_clr = '0;
        if (rd_ivr && higher) begin
            auto_clr[best] = ~ffe_eff[best]; // [RQ17] [RQ18]
        end
        if (rd_fvr) begin
            auto_clr[0] = 1'b1; // [RQ19]
        end
    end

    // Mask and fast-forcing command registers: one write sets or clears
    // any group of bits, so no read-modify-write race with handlers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= '0;
        end else if (wr_en) begin
            mask <= mask | hwdata; // [RQ13]
        end else if (wr_dis) begin
            mask <= mask & ~hwdata; // [RQ13]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ffe <= '0;
        end else if (wr_ffe) begin
            ffe <= ffe | hwdata;
        end else if (wr_ffd) begin
            ffe <= ffe & ~hwdata;
        end
    end

    assign ffe_eff = ffe | SRC_FAST_ONLY;

    // Mode, vector, spurious vector and general mask storage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NSRC; i++) begin
                mode[i] <= '0;
                vec[i] <= RESET_WORD;
            end
            spurious <= RESET_WORD;
            gmask <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode[idx].prio <= hwdata[MODE_PRIO_LSB +: PRIO_W]; // [RQ25]
                mode[idx].cond <= hwdata[MODE_COND_LSB +: 2];
            end
            if (wr_vec) begin
                vec[idx] <= hwdata;
            end
            if (wr_spur) begin
                spurious <= hwdata;
            end
            if (wr_ctrl) begin
                gmask <= hwdata[CTRL_GMASK_BIT];
            end
        end
    end

    // Arbitration over enabled, non-forced sources 1 to 31. Scanning
    // downward with >= leaves the lowest number on a tie.
    assign cand = pend & mask & ~ffe_eff; // [RQ14] [RQ5]
    always_comb begin
        best = '0;
        best_prio = '0;
        found = 1'b0;
        for (int i = NSRC - 1; i > 0; i--) begin
            if (cand[i] && (!found || mode[i].prio >= best_prio)) begin
                best = NUM_W'(i); // [RQ26]
                best_prio = mode[i].prio; // [RQ1] [RQ25]
                found = 1'b1;
            end
        end
    end

    // Only a strictly higher level than the one in service may interrupt.
    assign top = 3'(sp - SP_ONE);
    assign higher = found // [RQ27]
        && ((sp == '0) || (best_prio > stk_lvl[top]));
    assign fiq_cond = |(pend & mask & ffe_eff); // [RQ5] [RQ9]

    // Nesting stack: a vector read pushes the winner, end of service pops.
    assign push = rd_ivr && higher && (sp != SP_FULL);
    assign pop = wr_eos && (sp != '0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stk_num[i] <= '0;
                stk_lvl[i] <= '0;
            end
        end else if (push) begin
            stk_num[sp[2:0]] <= best; // [RQ28]
            stk_lvl[sp[2:0]] <= best_prio;
            sp <= sp + SP_ONE;
        end else if (pop) begin
            sp <= sp - SP_ONE; // [RQ27] [RQ28]
        end
    end

    // Request lines. The clock of this block is never gated, so wake-up
    // works from idle; the general mask holds the lines but keeps wake.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_request_n <= 1'b1;
            normal_request_n <= 1'b1;
            wake_request <= 1'b0;
        end else begin
            fast_request_n <= ~(fiq_cond & ~gmask); // [RQ2] [RQ8]
            normal_request_n <= ~(higher & ~gmask); // [RQ2] [RQ8]
            wake_request <= fiq_cond | higher; // [RQ6] [RQ7]
        end
    end

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        rd_val = RESET_WORD;
        if ((req.addr & BANK_MASK) == OFS_MODE_BASE) begin
            rd_val[MODE_PRIO_LSB +: PRIO_W] = mode[idx].prio;
            rd_val[MODE_COND_LSB +: 2] = mode[idx].cond;
        end else if ((req.addr & BANK_MASK) == OFS_VECTOR_BASE) begin
            rd_val = vec[idx];
        end else begin
            unique case (req.addr)
                OFS_VECTOR_READ: rd_val = higher ? vec[best] : spurious;
                OFS_FAST_VECTOR_READ: rd_val = vec[0];
                OFS_CURRENT_NUMBER: begin
                    if (sp != '0) begin
                        rd_val[NUM_W-1:0] = stk_num[top]; // [RQ21]
                    end
                end
                OFS_PENDING_STATUS: rd_val = pend; // [RQ20]
                OFS_MASK_STATUS: rd_val = mask; // [RQ13]
                OFS_CORE_LINE_IMAGE: begin
                    rd_val[LINE_FAST_BIT] = ~fast_request_n; // [RQ22]
                    rd_val[LINE_NORMAL_BIT] = ~normal_request_n;
                end
                OFS_SPURIOUS_VECTOR: rd_val = spurious;
                OFS_GENERAL_CTRL: rd_val[CTRL_GMASK_BIT] = gmask;
                OFS_FAST_FORCE_STATUS: rd_val = ffe_eff;
                default: rd_val = RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RESET_WORD;
        end else if (rd_go) begin
            hrdata <= rd_val;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_fast_line_drive: assert property ( // [RQ5]
        (fiq_cond && !gmask) |=> !fast_request_n)
        else $error("fast request line not asserted");
    a_gmask_holds_lines: assert property ( // [RQ8]
        (gmask && $past(gmask)) |-> (fast_request_n && normal_request_n))
        else $error("request line asserted under general mask");
    a_wake_follows_req: assert property ( // [RQ7]
        (!fast_request_n || !normal_request_n) |-> wake_request)
        else $error("request without wake indication");
    a_level_no_latch: assert property ( // [RQ16]
        (edge_q & ~$past(edge_mode)) == '0)
        else $error("latch set on a level-mode source");
    a_enable_cmd: assert property ( // [RQ13]
        wr_en |=> ((mask & $past(hwdata)) == $past(hwdata)))
        else $error("enable command did not set mask bits");
    a_disable_cmd: assert property ( // [RQ13]
        wr_dis |=> ((mask & $past(hwdata)) == '0))
        else $error("disable command did not clear mask bits");
    a_stack_push: assert property ( // [RQ28]
        push |=> (sp == $past(sp) + SP_ONE) && (stk_num[top] == $past(best)))
        else $error("vector read did not push current source");
    a_stack_pop: assert property ( // [RQ27]
        pop |=> (sp == $past(sp) - SP_ONE))
        else $error("end of service did not pop");
    a_fast_read_clear: assert property ( // [RQ19]
        (rd_fvr && !det_edge[0]) |=> !edge_q[0])
        else $error("fast vector read left source 0 latched");
    a_hold_lower: assert property ( // [RQ27]
        (!higher && !fiq_cond) |=> (normal_request_n && fast_request_n))
        else $error("request without higher priority source");

    // A vector read clears only the winner's latch; a new edge on the
    // winner in that same cycle sets it again, so it is left out here.
    a_vector_clear: assert property ( // [RQ17]
        (rd_ivr && higher && !det_edge[best]) |=> !edge_q[$past(best)])
        else $error("vector read left the current source latched");
    // Forced sources keep their latch through a vector read.
    a_forced_kept: assert property ( // [RQ18]
        rd_ivr |=> ((edge_q & $past(edge_q & ffe_eff))
                    == $past(edge_q & ffe_eff)))
        else $error("vector read cleared a fast-forced source");
    a_stack_full: assert property ( // [RQ28]
        (rd_ivr && sp == SP_FULL) |=> (sp == SP_FULL))
        else $error("push beyond eight nesting levels");
    // A read costs exactly one wait state, never more.
    a_read_wait: assert property (
        !hreadyout |=> hreadyout)
        else $error("read wait state longer than one cycle");

    c_forced_read: cover property (rd_ivr && (edge_q & ffe & ~SRC_FAST_ONLY) != '0);
    c_vector_push: cover property (push);
    c_nested_two: cover property (push && sp == SP_ONE);
    c_fast_read: cover property (rd_fvr && edge_q[0]);
    c_gmask_wake: cover property (gmask && wake_request);
endmodule

// ==== rtl/vpic_pkg.sv ====
// Functional notes
// RQ1 - 32 maskable sources are arbitrated over eight levels into a vector.
// RQ2 - Drive active-low fast and normal request lines to the processor.
// RQ3 - Internal sources select level or edge; polarity is fixed high.
// RQ4 - External sources select rising, falling, high or low level.
// RQ5 - Fast forcing routes any source to the fast line, not the normal one.
// RQ6 - The clock is never gated; power settings never change behaviour.
// RQ7 - Either request line asserting raises the wake-up indication.
// RQ8 - General mask keeps request lines high while still raising wake-up.
// RQ9 - Source 0 is the fast interrupt pin.
// RQ10 - Source 1 is the OR of the system peripheral interrupt lines.
// RQ11 - Sources 2 to 31 come from peripherals or external lines.
// RQ12 - Source number equals the attached peripheral identifier.
// RQ13 - Enable and disable commands change the mask; mask status reads it.
// RQ14 - A disabled source never affects arbitration or servicing of others.
// RQ15 - Set and clear commands set or clear edge latches, source 0 included.
// RQ16 - Set and clear commands do nothing to level-sensitive sources.
// RQ17 - Vector read clears the edge latch of the new current source only.
// RQ18 - Vector read never clears a fast-forced source.
// RQ19 - Fast vector read clears the edge latch of source 0.
// RQ20 - Pending status shows every source's activity, masked or not.
// RQ21 - Current number register returns the source now being serviced.
// RQ22 - Core line image shows the present fast and normal request lines.
// RQ23 - External latency is the same however the line reaches the block.
// RQ24 - External inputs are synchronised first; each edge latches once.
// RQ25 - Each source has a three-bit priority, 7 highest, 0 lowest.
// RQ26 - Equal top priority at vector read: the lowest source number wins.
// RQ27 - Equal or lower priorities wait until the end-of-service write.
// RQ28 - Eight-deep stack pushes number and level; end of service pops.
package vpic_pkg;
    localparam int NSRC = 32;
    localparam int AW = 12;
    localparam int DW = 32;
    localparam int PRIO_W = 3;
    localparam int NUM_W = 5;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 4;
    // Register map, byte offsets within the block.
    localparam logic [AW-1:0] OFS_MODE_BASE = 12'h000;
    localparam logic [AW-1:0] OFS_VECTOR_BASE = 12'h080;
    localparam logic [AW-1:0] BANK_MASK = 12'hF80;
    localparam int IDX_LSB = 2;
    localparam logic [AW-1:0] OFS_VECTOR_READ = 12'h100;
    localparam logic [AW-1:0] OFS_FAST_VECTOR_READ = 12'h104;
    localparam logic [AW-1:0] OFS_CURRENT_NUMBER = 12'h108;
    localparam logic [AW-1:0] OFS_PENDING_STATUS = 12'h10C;
    localparam logic [AW-1:0] OFS_MASK_STATUS = 12'h110;
    localparam logic [AW-1:0] OFS_CORE_LINE_IMAGE = 12'h114;
    localparam logic [AW-1:0] OFS_ENABLE_CMD = 12'h120;
    localparam logic [AW-1:0] OFS_DISABLE_CMD = 12'h124;
    localparam logic [AW-1:0] OFS_CLEAR_CMD = 12'h128;
    localparam logic [AW-1:0] OFS_SET_CMD = 12'h12C;
    localparam logic [AW-1:0] OFS_END_OF_SERVICE = 12'h130;
    localparam logic [AW-1:0] OFS_SPURIOUS_VECTOR = 12'h134;
    localparam logic [AW-1:0] OFS_GENERAL_CTRL = 12'h138;
    localparam logic [AW-1:0] OFS_FAST_FORCE_EN = 12'h140;
    localparam logic [AW-1:0] OFS_FAST_FORCE_DIS = 12'h144;
    localparam logic [AW-1:0] OFS_FAST_FORCE_STATUS = 12'h148;
    // Source mode field layout.
    localparam int MODE_PRIO_LSB = 0;
    localparam int MODE_COND_LSB = 5;
    localparam int COND_EDGE_BIT = 0;
    localparam int COND_INVERT_BIT = 1;
    localparam int LINE_FAST_BIT = 0;
    localparam int LINE_NORMAL_BIT = 1;
    localparam int CTRL_GMASK_BIT = 0;
    localparam logic [NSRC-1:0] SRC_FAST_ONLY = 32'h0000_0001;
    localparam logic [DW-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [SP_W-1:0] SP_ONE = 4'h1;
    localparam logic [SP_W-1:0] SP_FULL = 4'h8;

    typedef struct packed {
        logic [1:0] cond;
        logic [PRIO_W-1:0] prio;
    } vpic_mode_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic write;
    } vpic_req_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } vpic_bus_t;
endpackage

// ==== tb/vpic_src_model.sv ====
`timescale 1ns/1ps
module vpic_src_model #(
    parameter int NUM_SYS = 4
) (
    input wire logic hclk,
    input wire logic [31:0] want,
    output logic fast_source_pin,
    output logic [NUM_SYS-1:0] system_source,
    output logic [31:2] peripheral_source_id
);
    logic [NUM_SYS-1:0] rot;

    // Lines start low, as the peripherals do straight out of reset.
    initial begin
        rot = 1;
        fast_source_pin = 1'b0;
        system_source = '0;
        peripheral_source_id = '0;
    end

    // Lines move just after the edge, like a synchronous peripheral.
    // The active system line walks round, so every input of the OR is used.
    always @(posedge hclk) begin
        rot <= {rot[NUM_SYS-2:0], rot[NUM_SYS-1]};
        fast_source_pin <= want[0];
        system_source <= want[1] ? rot : '0;
        peripheral_source_id <= want[31:2];
    end
endmodule

// ==== tb/vpic_top_tb_top.sv ====
`timescale 1ns/1ps
module vpic_top_tb_top import vpic_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, dph, hreadyout, hresp;
    logic fast_request_n, normal_request_n, wake_request, fast_source_pin;
    logic [31:0] haddr, hwdata, hrdata, want, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] system_source;
    logic [31:2] peripheral_source_id;
    int failures, total_checks, cycles;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int src_n[6] = '{0, 5, 6, 7, 8, 10};
    int src_p[6] = '{0, 3, 4, 4, 6, 2};

    vpic_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .fast_source_pin(fast_source_pin),
        .system_source(system_source),
        .peripheral_source_id(peripheral_source_id),
        .fast_request_n(fast_request_n), .normal_request_n(normal_request_n),
        .wake_request(wake_request));

    vpic_src_model src_u (.hclk(hclk), .want(want),
        .fast_source_pin(fast_source_pin), .system_source(system_source),
        .peripheral_source_id(peripheral_source_id));

    // Free-running 40 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Address phase held until ready, then data phase held until ready.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= 1'b1;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // The expected word is noted first; the monitor judges the data phase.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        nm_q.push_back($sformatf("read %h", a));
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= 1'b0;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // Read data are taken at the first ready edge of a read data phase,
    // however many wait states the slave inserts.
    always @(posedge hclk) begin
        if (dph && hreadyout === 1'b1 && exp_q.size() > 0) begin
            chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
        end
        if (hreadyout === 1'b1) begin
            dph <= hsel && htrans[1] && !hwrite;
        end
    end

    // A hung handshake ends the run rather than stalling it forever.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        hwdata = '0;
        want = '0;
        dph = 1'b0;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        rv = $urandom(59);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_PENDING_STATUS, 32'h0);
        rd(OFS_MASK_STATUS, 32'h0);
        rd(OFS_CURRENT_NUMBER, 32'h0);
        rd(12'hFFC, 32'h0);
        rd(OFS_FAST_FORCE_STATUS, 32'h1);
        // Random levels on every source, all masked: pending still follows.
        for (int i = 0; i < 4; i++) begin
            rv = $urandom;
            want <= rv;
            cyc(8);
            rd(OFS_PENDING_STATUS, rv);
            chk("normal line", normal_request_n, 1'b1);
            chk("fast line", fast_request_n, 1'b1);
        end
        want <= '0;
        cyc(8);
        wr(OFS_SPURIOUS_VECTOR, 32'h5B);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_MODE_BASE + 12'(4 * src_n[i]), 32'h20 | src_p[i]);
            wr(OFS_VECTOR_BASE + 12'(4 * src_n[i]), 32'hA00 + src_n[i]);
        end
        wr(OFS_ENABLE_CMD, 32'h5E1);
        rd(OFS_MASK_STATUS, 32'h5E1);
        wr(OFS_DISABLE_CMD, 32'h400);
        rd(OFS_MASK_STATUS, 32'h1E1);
        // Software-set edge on source 5, taken and released.
        wr(OFS_SET_CMD, 32'h20);
        cyc(2);
        chk("normal line", normal_request_n, 1'b0);
        chk("wake", wake_request, 1'b1);
        rd(OFS_CORE_LINE_IMAGE, 32'h2);
        rd(OFS_VECTOR_READ, 32'hA05);
        cyc(1);
        chk("normal line", normal_request_n, 1'b1);
        rd(OFS_CURRENT_NUMBER, 32'h5);
        rd(OFS_PENDING_STATUS, 32'h0);
        wr(OFS_END_OF_SERVICE, 32'h0);
        rd(OFS_CURRENT_NUMBER, 32'h0);
        // Equal level tie, hold-off of the loser, then a nested higher one.
        wr(OFS_SET_CMD, 32'hC0);
        cyc(2);
        rd(OFS_VECTOR_READ, 32'hA06);
        cyc(1);
        chk("normal line", normal_request_n, 1'b1);
        rd(OFS_PENDING_STATUS, 32'h80);
        wr(OFS_SET_CMD, 32'h100);
        cyc(2);
        chk("normal line", normal_request_n, 1'b0);
        rd(OFS_VECTOR_READ, 32'hA08);
        rd(OFS_CURRENT_NUMBER, 32'h8);
        wr(OFS_END_OF_SERVICE, 32'h0);
        rd(OFS_CURRENT_NUMBER, 32'h6);
        wr(OFS_END_OF_SERVICE, 32'h0);
        cyc(2);
        chk("normal line", normal_request_n, 1'b0);
        rd(OFS_VECTOR_READ, 32'hA07);
        wr(OFS_END_OF_SERVICE, 32'h0);
        // Masked source 10 pends silently, then is forced onto the fast line.
        wr(OFS_SET_CMD, 32'h400);
        rd(OFS_PENDING_STATUS, 32'h400);
        cyc(2);
        chk("normal line", normal_request_n, 1'b1);
        wr(OFS_FAST_FORCE_EN, 32'h400);
        wr(OFS_ENABLE_CMD, 32'h400);
        cyc(2);
        chk("fast line", fast_request_n, 1'b0);
        chk("normal line", normal_request_n, 1'b1);
        rd(OFS_VECTOR_READ, 32'h5B);
        rd(OFS_PENDING_STATUS, 32'h400);
        wr(OFS_CLEAR_CMD, 32'h400);
        rd(OFS_PENDING_STATUS, 32'h0);
        cyc(2);
        chk("fast line", fast_request_n, 1'b1);
        wr(OFS_FAST_FORCE_DIS, 32'h400);
        rd(OFS_FAST_FORCE_STATUS, 32'h1);
        // Level source 9 ignores set commands.
        wr(OFS_SET_CMD, 32'h200);
        rd(OFS_PENDING_STATUS, 32'h0);
        // Rising edge on the fast pin, cleared by the fast vector read.
        want <= 32'h1;
        cyc(8);
        want <= 32'h0;
        chk("fast line", fast_request_n, 1'b0);
        rd(OFS_FAST_VECTOR_READ, 32'hA00);
        rd(OFS_PENDING_STATUS, 32'h0);
        cyc(2);
        chk("fast line", fast_request_n, 1'b1);
        // Low-level condition on external source 31 pends while it is low.
        wr(OFS_MODE_BASE + 12'h7C, 32'h40);
        rd(OFS_PENDING_STATUS, 32'h8000_0000);
        // General mask: wake-up without a request line.
        wr(OFS_GENERAL_CTRL, 32'h1);
        wr(OFS_SET_CMD, 32'h20);
        cyc(2);
        chk("normal line", normal_request_n, 1'b1);
        chk("wake", wake_request, 1'b1);
        wr(OFS_GENERAL_CTRL, 32'h0);
        cyc(2);
        chk("normal line", normal_request_n, 1'b0);
        conclude();
    end
endmodule
